// ### hw/mt_wrap_pkg.sv
// Constants of the multiturn wrap block.
// Summary of operation
// - Selector 1 treats encoder as incremental
// - Selector 2 treats a non-incremental encoder as single-turn absolute
// - Selector 0 follows native encoder type
// - Absolute use retains position, host reads it
// - Divided pulses emitted once after each restart, power-up included, in absolute use
// - Wrap limit 0..65535, default 65535, restart-latched
// - Reverse from zero loads wrap limit
// - Forward at wrap limit clears to zero
// - Alarm while drive and encoder limits differ in absolute use
// - Alarm persists until encoder limit rewritten
// - Single-turn mode forces zero count, no backup alarms
// - Batteryless multiturn needs firmware 0023 or later
package mt_wrap_pkg;

   // Register byte offsets on the AXI4-Lite slave.
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_USAGE      = 8'h04;
   localparam logic [7:0]  OFS_WRAP       = 8'h08;
   localparam logic [7:0]  OFS_ENC_WRAP   = 8'h0C;
   localparam logic [7:0]  OFS_STATUS     = 8'h10;
   localparam logic [7:0]  OFS_MTURN      = 8'h14;
   localparam logic [7:0]  OFS_SINGLE     = 8'h18;
   localparam logic [7:0]  OFS_FW_VER     = 8'h1C;

   // Control register bit positions.
   localparam int          CTRL_RESTART   = 0;
   localparam int          CTRL_ENC_WRITE = 1;

   // Encoder-usage selector digit values.
   localparam logic [1:0]  USAGE_NATIVE   = 2'h0;
   localparam logic [1:0]  USAGE_INCR     = 2'h1;
   localparam logic [1:0]  USAGE_SINGLE   = 2'h2;

   // Reset values and limits.
   localparam logic [15:0] WRAP_DEFAULT   = 16'hFFFF;
   localparam logic [15:0] FW_MIN_BATTLESS = 16'h0023;
   localparam logic [15:0] FW_VERSION     = 16'h0023;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // Divided pulse burst: pulse count sent once after a restart, and half-period.
   localparam logic [15:0] BURST_PULSES   = 16'h0004;
   localparam int          PULSE_HALF_NS  = 50;
   localparam int          CLK_PERIOD_NS  = 5;
   localparam logic [7:0]  PULSE_HALF_CYC = 8'(PULSE_HALF_NS / CLK_PERIOD_NS);

   // Native encoder type as reported by the attached encoder.
   typedef enum logic [1:0] {
      ENC_INCR,
      ENC_SINGLE,
      ENC_MULTI,
      ENC_MULTI_BATTLESS
   } enc_type_e;

   // Effective usage mode, latched at restart.
   typedef enum logic [1:0] {
      MODE_INCR,
      MODE_SINGLE,
      MODE_MULTI
   } mode_e;

endpackage

// ### hw/mt_turn_counter.sv
// Multiturn revolution counter with configurable wrap limit.
`timescale 1ns/1ps
module mt_turn_counter
   import mt_wrap_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        load,
   input  wire logic [15:0] load_value,
   input  wire logic        force_zero,
   input  wire logic        wrap_en,
   input  wire logic [15:0] wrap_limit,
   input  wire logic        rev_fwd,
   input  wire logic        rev_rev,
   output logic      [15:0] count
);

   logic [15:0] count_r;    // Revolution count, unsigned.
   logic [15:0] count_nxt;  // Next count.

   // Custom limits wrap both ways.
   always_comb begin
      count_nxt = count_r;
      if (force_zero) begin
         count_nxt = 16'h0000;
      end else if (load) begin
         count_nxt = load_value;
      end else if (rev_fwd && !rev_rev) begin
         if (wrap_en && count_r == wrap_limit) begin
            count_nxt = 16'h0000;
         end else begin
            count_nxt = 16'(count_r + 16'h0001);
         end
      end else if (rev_rev && !rev_fwd) begin
         if (wrap_en && count_r == 16'h0000) begin
            count_nxt = wrap_limit;
         end else begin
            count_nxt = 16'(count_r - 16'h0001);
         end
      end
   end

   // State register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_r <= 16'h0000;
      end else begin
         count_r <= count_nxt;
      end
   end

   assign count = count_r;

endmodule

// ### hw/mt_pulse_burst.sv
// One-shot divided quadrature burst.
`timescale 1ns/1ps
module mt_pulse_burst
   import mt_wrap_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        start,
   input  wire logic [15:0] pulses,
   output logic             phase_a,
   output logic             phase_b,
   output logic             phase_c,
   output logic             busy
);

   logic [15:0] left_r,  left_nxt;   // Quarter-steps remaining.
   logic [7:0]  tmr_r,   tmr_nxt;    // Half-period timer.
   logic [1:0]  step_r,  step_nxt;   // Quadrature step.
   logic        busy_r,  busy_nxt;   // Burst in progress.
   logic [2:0]  out_r,   out_nxt;    // Registered phase outputs.

   // Step the gray sequence 00,01,11,10 at each half-period timer expiry; C marks the pulse that starts with pulses/4 pulses left, the last of 4.
   always_comb begin
      left_nxt = left_r;
      tmr_nxt  = tmr_r;
      step_nxt = step_r;
      busy_nxt = busy_r;
      out_nxt  = out_r;
      if (!busy_r) begin
         out_nxt = 3'h0;
         if (start && pulses != 16'h0000) begin
            busy_nxt = 1'b1;
            left_nxt = {pulses[13:0], 2'b00};
            tmr_nxt  = PULSE_HALF_CYC;
            step_nxt = 2'h0;
         end
      end else if (tmr_r != 8'h00) begin
         tmr_nxt = 8'(tmr_r - 8'h01);
      end else begin
         tmr_nxt  = PULSE_HALF_CYC;
         step_nxt = 2'(step_r + 2'h1);
         left_nxt = 16'(left_r - 16'h0001);
         out_nxt  = {left_r[15:2] == {2'b00, pulses[13:2]} && pulses[1:0] == 2'b00
                     && step_r == 2'h0,
                     step_r[1], step_r[1] ^ step_r[0]};
         if (left_r == 16'h0001) begin
            busy_nxt = 1'b0;
         end
      end
   end

   // State registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         left_r <= 16'h0000;
         tmr_r  <= 8'h00;
         step_r <= 2'h0;
         busy_r <= 1'b0;
         out_r  <= 3'h0;
      end else begin
         left_r <= left_nxt;
         tmr_r  <= tmr_nxt;
         step_r <= step_nxt;
         busy_r <= busy_nxt;
         out_r  <= out_nxt;
      end
   end

   assign phase_c = out_r[2];
   assign phase_a = out_r[1];
   assign phase_b = out_r[0];
   assign busy    = busy_r;

endmodule

// ### hw/multiturn_position_wrap.sv
// Multiturn wrap top with AXI4-Lite slave.
`timescale 1ns/1ps
module multiturn_position_wrap
   import mt_wrap_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave.
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Encoder side.
   input  wire logic [1:0]  enc_type,
   input  wire logic        enc_rev_fwd,
   input  wire logic        enc_rev_rev,
   input  wire logic [15:0] enc_turns,
   input  wire logic [15:0] enc_stored_limit,
   input  wire logic        enc_backup_fault,
   input  wire logic        enc_battery_low,
   output logic             enc_limit_write,
   output logic [15:0]      enc_limit_value,
   // Divided pulse outputs and alarm.
   output logic             divided_pulse_phase_a,
   output logic             divided_pulse_phase_b,
   output logic             divided_pulse_phase_c,
   output logic             wrap_limit_mismatch_alarm
);

   // Software-visible settings; they act at a restart, except the limit sent by an encoder write.
   logic [1:0]  encoder_usage_select_r, encoder_usage_select_nxt;  // Selector digit.
   logic [15:0] multiturn_wrap_limit_r, multiturn_wrap_limit_nxt;  // Stored limit.

   // Values latched at restart and used by the running logic.
   logic [15:0] act_limit_r, act_limit_nxt;     // Active wrap limit.
   mode_e       mode_r,      mode_nxt;          // Effective usage mode.
   logic        restart_r,   restart_nxt;       // One-cycle restart strobe.
   logic        init_r,      init_nxt;          // Power-up restart pending.
   logic        unsupp_r,    unsupp_nxt;        // Batteryless encoder unsupported.

   // Encoder limit write strobe toward the encoder.
   logic        enc_wr_r,    enc_wr_nxt;        // Write pulse.
   logic [15:0] enc_val_r,   enc_val_nxt;       // Value written.

   // Alarm and status outputs.
   logic        alarm_r,     alarm_nxt;         // Mismatch alarm.
   logic        bk_alm_r,    bk_alm_nxt;        // Backup alarm.
   logic        bt_alm_r,    bt_alm_nxt;        // Battery alarm.

   // AXI slave state.
   logic        aw_ok_r,  aw_ok_nxt; // Write address held.
   logic        w_ok_r,   w_ok_nxt; // Write data held.
   logic [7:0]  awaddr_r, awaddr_nxt; // Latched write address.
   logic [31:0] wdata_r,  wdata_nxt; // Latched write data.
   logic [3:0]  wstrb_r,  wstrb_nxt; // Latched strobes.
   logic        bvalid_r, bvalid_nxt; // Write response valid.
   logic [1:0]  bresp_r,  bresp_nxt; // Write response code.
   logic        rvalid_r, rvalid_nxt; // Read data valid.
   logic [31:0] rdata_r,  rdata_nxt; // Read data.
   logic [1:0]  rresp_r,  rresp_nxt; // Read response code.
   logic        arrdy_r,  arrdy_nxt; // Read address ready.

   // Internal wires.
   logic [15:0] mt_count; // Multiturn count.
   logic        burst_busy; // Pulse burst running.
   logic        pa, pb, pc; // Pulse generator phases.
   logic        do_write; // Write committed this cycle.
   logic        abs_used; // Absolute mode active.

   // Byte-lane merge of a 16-bit field.
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
      logic [15:0] r;
      r = old;
      if (s[0]) r[7:0]  = d[7:0];
      if (s[1]) r[15:8] = d[15:8];
      return r;
   endfunction

   // Aligned words up to the last register are mapped.
   function automatic logic is_mapped(input logic [7:0] a);
      return a <= OFS_FW_VER && a[1:0] == 2'h0;
   endfunction

   assign abs_used = (mode_r != MODE_INCR);
   assign do_write = aw_ok_r && w_ok_r && !bvalid_r;

   // Write channel: accept address and data in any order, answer after both.
   always_comb begin
      aw_ok_nxt  = aw_ok_r;
      w_ok_nxt   = w_ok_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt  = wdata_r;
      wstrb_nxt  = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt  = bresp_r;
      if (s_axi_awvalid && !aw_ok_r) begin
         aw_ok_nxt  = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_ok_r) begin
         w_ok_nxt  = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (do_write) begin
         bvalid_nxt = 1'b1;
         bresp_nxt  = is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
         aw_ok_nxt  = 1'b0;
         w_ok_nxt   = 1'b0;
      end
   end

   // Read channel: one read at a time, answered the cycle after acceptance.
   always_comb begin
      arrdy_nxt  = !rvalid_r && !(s_axi_arvalid && arrdy_r);
      rvalid_nxt = rvalid_r;
      rdata_nxt  = rdata_r;
      rresp_nxt  = rresp_r;
      if (s_axi_arvalid && arrdy_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr)
            OFS_USAGE:    rdata_nxt = {30'h0, encoder_usage_select_r};
            OFS_WRAP:     rdata_nxt = {16'h0, multiturn_wrap_limit_r};
            OFS_ENC_WRAP: rdata_nxt = {16'h0, enc_stored_limit};
            OFS_STATUS:   rdata_nxt = {25'h0, unsupp_r, bt_alm_r, bk_alm_r,
                                       mode_r == MODE_MULTI && enc_type == ENC_MULTI,
                                       mode_r == MODE_MULTI, abs_used, alarm_r};
            OFS_MTURN:    rdata_nxt = {16'h0, mt_count};
            OFS_SINGLE:   rdata_nxt = {16'h0, act_limit_r};
            OFS_FW_VER:   rdata_nxt = {16'h0, FW_VERSION};
            default:      rdata_nxt = 32'h0000_0000;
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   // Settings, restart handling and encoder write strobe.
   always_comb begin
      encoder_usage_select_nxt = encoder_usage_select_r;
      multiturn_wrap_limit_nxt = multiturn_wrap_limit_r;
      restart_nxt = init_r;
      init_nxt    = 1'b0;
      enc_wr_nxt  = 1'b0;
      enc_val_nxt = enc_val_r;
      if (do_write) begin
         unique case (awaddr_r)
            OFS_USAGE: begin
               if (wstrb_r[0]) encoder_usage_select_nxt = wdata_r[1:0];
            end
            OFS_WRAP: begin
               // Full 16-bit range is legal, so no clamp is needed.
               multiturn_wrap_limit_nxt = merge16(multiturn_wrap_limit_r, wdata_r,
                                                  wstrb_r);
            end
            OFS_CTRL: begin
               if (wstrb_r[0] && wdata_r[CTRL_RESTART]) restart_nxt = 1'b1;
               if (wstrb_r[0] && wdata_r[CTRL_ENC_WRITE]) begin
                  enc_wr_nxt  = 1'b1;
                  enc_val_nxt = multiturn_wrap_limit_r;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Latch mode and limit at restart.
   always_comb begin
      mode_nxt      = mode_r;
      act_limit_nxt = act_limit_r;
      unsupp_nxt    = unsupp_r;
      if (restart_r) begin
         act_limit_nxt = multiturn_wrap_limit_r;
         unsupp_nxt    = 1'b0;
         unique case (encoder_usage_select_r)
            USAGE_INCR:   mode_nxt = MODE_INCR;
            USAGE_SINGLE: mode_nxt = (enc_type == ENC_INCR) ? MODE_INCR : MODE_SINGLE;
            default: begin
               // Native type decides; multiturn with battery follows it.
               unique case (enc_type)
                  ENC_INCR:   mode_nxt = MODE_INCR;
                  ENC_SINGLE: mode_nxt = MODE_SINGLE;
                  ENC_MULTI:  mode_nxt = MODE_MULTI;
                  default: begin
                     // Older firmware cannot run a batteryless multiturn encoder.
                     if (FW_VERSION >= FW_MIN_BATTLESS) begin
                        mode_nxt = MODE_MULTI;
                     end else begin
                        mode_nxt   = MODE_SINGLE;
                        unsupp_nxt = 1'b1;
                     end
                  end
               endcase
            end
         endcase
      end
   end

   // Live compare: the alarm stays until the encoder agrees.
   always_comb begin
      alarm_nxt  = abs_used && (act_limit_r != enc_stored_limit);
      bk_alm_nxt = (mode_r == MODE_MULTI) && enc_backup_fault;
      bt_alm_nxt = (mode_r == MODE_MULTI) && enc_type == ENC_MULTI
                   && enc_battery_low;
   end

   // Registers of the top level.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         encoder_usage_select_r <= USAGE_NATIVE;
         multiturn_wrap_limit_r <= WRAP_DEFAULT;
         act_limit_r <= WRAP_DEFAULT;
         mode_r      <= MODE_INCR;
         restart_r   <= 1'b0;
         init_r      <= 1'b1;
         unsupp_r    <= 1'b0;
         enc_wr_r    <= 1'b0;
         enc_val_r   <= 16'h0000;
         alarm_r     <= 1'b0;
         bk_alm_r    <= 1'b0;
         bt_alm_r    <= 1'b0;
         aw_ok_r     <= 1'b0;
         w_ok_r      <= 1'b0;
         awaddr_r    <= 8'h00;
         wdata_r     <= 32'h0000_0000;
         wstrb_r     <= 4'h0;
         bvalid_r    <= 1'b0;
         bresp_r     <= RESP_OKAY;
         rvalid_r    <= 1'b0;
         rdata_r     <= 32'h0000_0000;
         rresp_r     <= RESP_OKAY;
         arrdy_r     <= 1'b0;
      end else begin
         encoder_usage_select_r <= encoder_usage_select_nxt;
         multiturn_wrap_limit_r <= multiturn_wrap_limit_nxt;
         act_limit_r <= act_limit_nxt;
         mode_r      <= mode_nxt;
         restart_r   <= restart_nxt;
         init_r      <= init_nxt;
         unsupp_r    <= unsupp_nxt;
         enc_wr_r    <= enc_wr_nxt;
         enc_val_r   <= enc_val_nxt;
         alarm_r     <= alarm_nxt;
         bk_alm_r    <= bk_alm_nxt;
         bt_alm_r    <= bt_alm_nxt;
         aw_ok_r     <= aw_ok_nxt;
         w_ok_r      <= w_ok_nxt;
         awaddr_r    <= awaddr_nxt;
         wdata_r     <= wdata_nxt;
         wstrb_r     <= wstrb_nxt;
         bvalid_r    <= bvalid_nxt;
         bresp_r     <= bresp_nxt;
         rvalid_r    <= rvalid_nxt;
         rdata_r     <= rdata_nxt;
         rresp_r     <= rresp_nxt;
         arrdy_r     <= arrdy_nxt;
      end
   end

   // Count revolutions; the wrap only applies with a non-default limit.
   mt_turn_counter u_counter (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .load       (restart_r && mode_nxt == MODE_MULTI),
      .load_value (enc_turns),
      .force_zero (mode_r != MODE_MULTI && !restart_r),
      .wrap_en    (act_limit_r != WRAP_DEFAULT),
      .wrap_limit (act_limit_r),
      .rev_fwd    (enc_rev_fwd),
      .rev_rev    (enc_rev_rev),
      .count      (mt_count)
   );

   // One burst per restart in absolute mode.
   mt_pulse_burst u_burst (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (restart_r && enc_type != ENC_INCR && encoder_usage_select_r != USAGE_INCR),
      .pulses  (BURST_PULSES),
      .phase_a (pa),
      .phase_b (pb),
      .phase_c (pc),
      .busy    (burst_busy)
   );

   // Output stage, so outputs come from flops.
   logic [2:0] pulse_r; // Output stage.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pulse_r <= 3'h0;
      end else begin
         pulse_r <= burst_busy ? {pc, pb, pa} : 3'h0;
      end
   end

   assign divided_pulse_phase_a     = pulse_r[0];
   assign divided_pulse_phase_b     = pulse_r[1];
   assign divided_pulse_phase_c     = pulse_r[2];
   assign wrap_limit_mismatch_alarm = alarm_r;
   assign enc_limit_write = enc_wr_r;
   assign enc_limit_value = enc_val_r;
   assign s_axi_awready   = !aw_ok_r;
   assign s_axi_wready    = !w_ok_r;
   assign s_axi_bvalid    = bvalid_r;
   assign s_axi_bresp     = bresp_r;
   assign s_axi_arready   = arrdy_r;
   assign s_axi_rvalid    = rvalid_r;
   assign s_axi_rdata     = rdata_r;
   assign s_axi_rresp     = rresp_r;

endmodule

// ### dv/mt_wrap_asserts.sv
// Port-level concurrent checks for the multiturn wrap block.
`timescale 1ns/1ps
module mt_wrap_asserts
   import mt_wrap_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        enc_limit_write,
   input wire logic        divided_pulse_phase_a,
   input wire logic        wrap_limit_mismatch_alarm
);
   // One clock domain for all checks.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped early");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped early");
   AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while pending");
   AST_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while pending");
   AST_B_UNMAP: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr > 8'h1C
      |-> ##[1:100] s_axi_bvalid && s_axi_bresp == RESP_SLVERR) else $error("no error resp");
   AST_PULSE_STEP: assert property ($changed(divided_pulse_phase_a)
      |=> $stable(divided_pulse_phase_a) [*8]) else $error("pulse step too short");
   AST_LIM_WR: assert property (enc_limit_write |=> !enc_limit_write)
      else $error("encoder write not a single pulse");
   C_ALARM: cover property ($rose(wrap_limit_mismatch_alarm));
   C_PULSE: cover property ($rose(divided_pulse_phase_a));
   C_ENC_WR: cover property (enc_limit_write);
endmodule
bind multiturn_position_wrap mt_wrap_asserts i_chk (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .enc_limit_write, .divided_pulse_phase_a, .wrap_limit_mismatch_alarm);

// ### dv/mt_encoder_model.sv
// Behavioural rotary encoder facing the wrap block.
`timescale 1ns/1ps
module mt_encoder_model
   import mt_wrap_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        enc_limit_write,
   input  wire logic [15:0] enc_limit_value,
   output logic      [1:0]  enc_type,
   output logic             enc_rev_fwd,
   output logic             enc_rev_rev,
   output logic      [15:0] enc_turns,
   output logic      [15:0] enc_stored_limit,
   output logic             enc_backup_fault,
   output logic             enc_battery_low
);
   // The bench steers these.
   initial begin
      enc_type = ENC_MULTI;
      enc_rev_fwd = 1'b0;
      enc_rev_rev = 1'b0;
      enc_turns = 16'h0007;
      enc_stored_limit = WRAP_DEFAULT;
      enc_backup_fault = 1'b1;
      enc_battery_low = 1'b1;
   end
   // Keeps its limit until written.
   always @(posedge aclk) begin
      if (enc_limit_write) enc_stored_limit <= enc_limit_value;
   end
   // One revolution crossing is a single-cycle pulse.
   task automatic spin(input logic fwd);
      @(posedge aclk);
      enc_rev_fwd <= fwd;
      enc_rev_rev <= !fwd;
      @(posedge aclk);
      enc_rev_fwd <= 1'b0;
      enc_rev_rev <= 1'b0;
   endtask
endmodule

// ### dv/multiturn_position_wrap_tb_top.sv
// Self-checking bench for the multiturn wrap block.
`timescale 1ns/1ps
module multiturn_position_wrap_tb_top
   import mt_wrap_pkg::*;
;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, enc_rev_fwd, enc_rev_rev, enc_backup_fault, enc_battery_low;
   logic        enc_limit_write, divided_pulse_phase_a, divided_pulse_phase_b;
   logic        divided_pulse_phase_c, wrap_limit_mismatch_alarm;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, enc_type;
   logic [15:0] enc_turns, enc_stored_limit, enc_limit_value;
   int          err_count, total_checks, pulses, cyc;
   multiturn_position_wrap i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .enc_type, .enc_rev_fwd,
      .enc_rev_rev, .enc_turns, .enc_stored_limit, .enc_backup_fault, .enc_battery_low,
      .enc_limit_write, .enc_limit_value, .divided_pulse_phase_a, .divided_pulse_phase_b,
      .divided_pulse_phase_c, .wrap_limit_mismatch_alarm);
   mt_encoder_model i_enc (.aclk, .enc_limit_write, .enc_limit_value, .enc_type, .enc_rev_fwd,
      .enc_rev_rev, .enc_turns, .enc_stored_limit, .enc_backup_fault, .enc_battery_low);
   // Phase A rises once per pulse.
   always @(posedge divided_pulse_phase_a) pulses++;
   // Hang guard.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   // Write master; bready follows bvalid.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (int i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      s_axi_bready <= 1'b0;
      chk("bresp", 32'(s_axi_bresp), 32'(er));
   endtask
   // Read master; masked compare.
   task automatic rc(input string n, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (int i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      s_axi_rready <= 1'b0;
      chk(n, s_axi_rdata & m, e);
      chk("rresp", 32'(s_axi_rresp), 32'(er));
   endtask
   task automatic restart();
      pulses = 0;
      wr(OFS_CTRL, 32'h1, RESP_OKAY);
      repeat (6) @(posedge aclk);
   endtask
   task automatic t_defaults();
      rc("wrap", OFS_WRAP, 32'hFFFF, 32'hFFFF);
      rc("usage", OFS_USAGE, 32'h3, 32'h0);
      rc("fw", OFS_FW_VER, 32'hFFFF, 32'h0023);
      rc("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
      wr(8'h24, 32'h1, RESP_SLVERR);
      $display("test defaults done");
   endtask
   task automatic t_modes();
      logic [31:0] msk[3] = '{32'h3E, 32'h0E, 32'h3E};
      logic [31:0] sx[3] = '{32'h3E, 32'h00, 32'h02};
      for (int u = 0; u < 3; u++) begin
         wr(OFS_USAGE, 32'(u), RESP_OKAY);
         restart();
         repeat (300) @(posedge aclk);
         i_enc.spin(1'b1);
         repeat (3) @(posedge aclk);
         rc("status", OFS_STATUS, msk[u], sx[u]);
         rc("count", OFS_MTURN, 32'hFFFF, u == 0 ? 32'h8 : 32'h0);
         chk("pulses", 32'(pulses), u == 1 ? 32'h0 : 32'(BURST_PULSES));
      end
      i_enc.enc_type <= ENC_MULTI_BATTLESS;
      wr(OFS_USAGE, 32'h0, RESP_OKAY);
      restart();
      rc("battless", OFS_STATUS, 32'h42, 32'h02);
      $display("test modes done");
   endtask
   task automatic t_wrap();
      i_enc.enc_type <= ENC_MULTI;
      i_enc.enc_turns <= 16'h0000;
      wr(OFS_WRAP, 32'd99, RESP_OKAY);
      restart();
      rc("latched", OFS_SINGLE, 32'hFFFF, 32'd99);
      chk("alarm", 32'(wrap_limit_mismatch_alarm), 32'h1);
      i_enc.spin(1'b0);
      rc("count", OFS_MTURN, 32'hFFFF, 32'd99);
      i_enc.spin(1'b1);
      rc("count", OFS_MTURN, 32'hFFFF, 32'h0);
      wr(OFS_CTRL, 32'h2, RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk("alarm", 32'(wrap_limit_mismatch_alarm), 32'h0);
      rc("status", OFS_STATUS, 32'h1, 32'h0);
      $display("test wrap done");
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      t_defaults();
      t_modes();
      t_wrap();
      end_of_test();
   end
endmodule
